// ==== design/ccad_pkg.sv ====
// Shared constants, opcodes and types for the CPU front end.
package ccad_pkg;
	// ==========================================================
	// Opcodes of the subset that this front end decodes.
	localparam logic [7:0] PRE_Y = 8'h18;
	localparam logic [7:0] OP_ABX = 8'h3a;
	localparam logic [7:0] OP_TAP = 8'h06;
	localparam logic [7:0] OP_RTI = 8'h3b;
	localparam logic [7:0] OP_STOP = 8'hcf;
	localparam logic [3:0] LO_ADC = 4'h9;
	localparam logic [3:0] LO_AND = 4'h4;
	localparam logic [3:0] LO_ADD_WIDE_TO_DOUBLE_ACC = 4'h3;
	localparam logic [3:0] HI_BRANCH = 4'h2;
	// ==========================================================
	// Flag positions in the condition flags register.
	localparam int CC_C = 0;
	localparam int CC_V = 1;
	localparam int CC_Z = 2;
	localparam int CC_N = 3;
	localparam int CC_I = 4;
	localparam int CC_H = 5;
	localparam int CC_X = 6;
	localparam int CC_S = 7;
	localparam logic [7:0] CCR_RESET = 8'hd0;
	// ==========================================================
	// Vector and stacking figures.
	localparam logic [15:0] VEC_PIN = 16'hfff4;
	localparam logic [3:0] PUSH_LAST = 4'h8;
	// ==========================================================
	// Documented E-clock cycle counts.
	localparam logic [3:0] CYC_IMM = 4'h2;
	localparam logic [3:0] CYC_DIR = 4'h3;
	localparam logic [3:0] CYC_EXT = 4'h4;
	localparam logic [3:0] CYC_IDX = 4'h4;
	localparam logic [3:0] CYC_IDY = 4'h5;
	localparam logic [3:0] CYC_WIDE = 4'h2;
	localparam logic [3:0] CYC_ABX = 4'h3;
	localparam logic [3:0] CYC_ABY = 4'h4;
	// ==========================================================
	// Register bus indices.
	localparam logic [2:0] RA_CTRL = 3'h0;
	localparam logic [2:0] RA_STATUS = 3'h1;
	localparam logic [2:0] RA_ACC = 3'h2;
	localparam logic [2:0] RA_X = 3'h3;
	localparam logic [2:0] RA_Y = 3'h4;
	localparam logic [2:0] RA_SP = 3'h5;
	localparam logic [2:0] RA_PC = 3'h6;
	localparam logic [2:0] RA_CCR = 3'h7;
	// ==========================================================
	// Types.
	typedef enum logic [3:0] {K_NOP, K_ABX, K_ABY, K_ADC, K_AND, K_ADD_WIDE_TO_DOUBLE_ACC, K_TAP, K_RTI, K_STOP, K_BR} ccad_kind_t;
	typedef enum logic [2:0] {M_INH, M_IMM, M_DIR, M_EXT, M_IDX, M_REL} ccad_mode_t;
	typedef struct packed {
		ccad_kind_t kind;
		ccad_mode_t mode;
		logic use_y;
		logic wide;
		logic [1:0] nopnd;
	} ccad_dec_t;
	typedef struct packed {
		logic [15:0] addr;
		logic rd;
		logic wr;
		logic [7:0] wdata;
	} ccad_mem_req_t;
endpackage

// ==== design/ccad_alu.sv ====
// Arithmetic and flag logic for the add, AND and transfer instructions.
`timescale 1ns/1ns
`default_nettype none
module ccad_alu
	import ccad_pkg::*;
(
	input wire ccad_pkg::ccad_kind_t kind,
	input wire logic [15:0] acc_d,
	input wire logic [15:0] idx_x,
	input wire logic [15:0] idx_y,
	input wire logic [15:0] src,
	input wire logic [7:0] ccr_in,
	output logic [15:0] res,
	output logic [7:0] ccr_out
);
	// ==========================================================
	// Datapath terms.
	wire [7:0] a = acc_d[15:8];
	wire [7:0] m = src[7:0];
	wire [8:0] adc_sum = {1'b0, a} + {1'b0, m} + {8'h00, ccr_in[CC_C]};
	wire [4:0] adc_half = {1'b0, a[3:0]} + {1'b0, m[3:0]} + {4'h0, ccr_in[CC_C]};
	wire [16:0] wsum = {1'b0, acc_d} + {1'b0, src};
	wire [7:0] and_r = a & m;

	// Result and flags per instruction; unlisted flags keep their value.
	always_comb begin
		res = acc_d;
		ccr_out = ccr_in;
		case (kind)
			K_ADC: begin
				res = {adc_sum[7:0], acc_d[7:0]};
				ccr_out[CC_H] = adc_half[4];
				ccr_out[CC_N] = adc_sum[7];
				ccr_out[CC_Z] = adc_sum[7:0] == 8'h00;
				ccr_out[CC_V] = (a[7] == m[7]) && (adc_sum[7] != a[7]);
				ccr_out[CC_C] = adc_sum[8];
			end
			K_AND: begin
				res = {and_r, acc_d[7:0]};
				ccr_out[CC_N] = and_r[7];
				ccr_out[CC_Z] = and_r == 8'h00;
				ccr_out[CC_V] = 1'b0;
			end
			K_ADD_WIDE_TO_DOUBLE_ACC: begin
				res = wsum[15:0];
				ccr_out[CC_N] = wsum[15];
				ccr_out[CC_Z] = wsum[15:0] == 16'h0000;
				ccr_out[CC_V] = (acc_d[15] == src[15]) && (wsum[15] != acc_d[15]);
				ccr_out[CC_C] = wsum[16];
			end
			// Index adds zero-extend B and touch no flag.
			K_ABX: res = idx_x + {8'h00, acc_d[7:0]};
			K_ABY: res = idx_y + {8'h00, acc_d[7:0]};
			// The pin mask may be cleared from A but never set this way.
			K_TAP: ccr_out = {a[7], a[6] & ccr_in[CC_X], a[5:0]};
			default: begin
				res = acc_d;
				ccr_out = ccr_in;
			end
		endcase
	end
endmodule
`default_nettype wire

// ==== design/ccad_core.sv ====
// CPU front end: decode, effective address, flags, stacking and register port.
// Operation
// - Reset sets the pin interrupt mask.
// - Masks set after stacking, before vector fetch.
// - Pin mask cleared only by TAP or return.
// - Halt with stop-disable set acts as no-op.
// - Words big-endian, no alignment restriction.
// - Prebyte selects another page of opcodes.
// - Prebyte, opcode, zero to two operands.
// - Immediate operands follow opcode, sized to register.
// - Direct mode forces high address byte zero.
// - Extended mode takes two address bytes.
// - Indexed adds unsigned offset to index register.
// - Inherent uses opcode only, no address.
// - Taken branch adds signed offset to counter.
// - Add B to first index, flags unchanged.
// - Prebyte form adds B to second index.
// - Add with carry updates five flags.
// - Wide add to double accumulator, four flags.
// - AND clears overflow, sets negative and zero.
`timescale 1ns/1ns
`default_nettype none
module ccad_core
	import ccad_pkg::*;
(
	input wire logic ref_clk,
	input wire logic resetn,
	input wire logic ce,
	input wire logic [2:0] reg_addr,
	input wire logic [15:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [15:0] reg_rdata,
	output ccad_pkg::ccad_mem_req_t mem_req,
	input wire logic [7:0] mem_rdata,
	input wire logic nonmaskable_pin_request_n,
	output logic stopped
);
	typedef enum logic [3:0] {ST_IDLE, ST_FETCH, ST_OPND, ST_DATA, ST_EXEC, ST_PUSH, ST_VEC, ST_PULL,
		ST_STOP} ccad_state_t;

	ccad_state_t state_reg;
	ccad_dec_t dec_reg;
	logic [15:0] acc_reg, x_reg, y_reg, sp_reg, pc_reg, ea_reg, opnd_reg, data_reg;
	logic [7:0] ccr_reg;
	logic [3:0] cnt_reg, cyc_reg;
	logic [1:0] ph_reg;
	logic pre_reg, run_reg;
	logic [15:0] alu_res;
	logic [7:0] alu_ccr;

	// ==========================================================
	// Decode of one opcode byte on the page chosen by the prebyte.
	function automatic ccad_dec_t decode(input logic pre, input logic [7:0] op);
		ccad_dec_t d;
		logic is_alu;
		d = '{K_NOP, M_INH, 1'b0, 1'b0, 2'd0};
		is_alu = (op[7:6] == 2'b10 && (op[3:0] == LO_ADC || op[3:0] == LO_AND))
			|| (op[7:6] == 2'b11 && op[3:0] == LO_ADD_WIDE_TO_DOUBLE_ACC);
		if (op == OP_ABX) begin
			d.kind = pre ? K_ABY : K_ABX;
		end else if (is_alu) begin
			d.kind = (op[3:0] == LO_ADC) ? K_ADC : (op[3:0] == LO_AND) ? K_AND : K_ADD_WIDE_TO_DOUBLE_ACC;
			d.wide = d.kind == K_ADD_WIDE_TO_DOUBLE_ACC;
			case (op[5:4])
				2'b00: d.mode = M_IMM;
				2'b01: d.mode = M_DIR;
				2'b10: d.mode = M_IDX;
				default: d.mode = M_EXT;
			endcase
			d.use_y = pre;
			// Operand count gives lengths of two to three bytes.
			d.nopnd = (d.mode == M_EXT || (d.mode == M_IMM && d.wide)) ? 2'd2 : 2'd1;
			// The second page holds only the indexed forms.
			if (pre && d.mode != M_IDX) begin
				d = '{K_NOP, M_INH, 1'b0, 1'b0, 2'd0};
			end
		end else if (!pre) begin
			if (op == OP_TAP) begin
				d.kind = K_TAP;
			end else if (op == OP_RTI) begin
				d.kind = K_RTI;
			end else if (op == OP_STOP) begin
				d.kind = K_STOP;
			end else if (op[7:4] == HI_BRANCH && (op[3:0] == 4'h0 || op[3:2] == 2'b01)) begin
				d.kind = K_BR;
				d.mode = M_REL;
				d.nopnd = 2'd1;
			end
		end
		return d;
	endfunction

	// Documented cycle budget of a decoded instruction.
	function automatic logic [3:0] doc_cycles(input ccad_dec_t d);
		logic [3:0] c;
		case (d.mode)
			M_IMM: c = CYC_IMM;
			M_DIR: c = CYC_DIR;
			M_EXT: c = CYC_EXT;
			M_IDX: c = d.use_y ? CYC_IDY : CYC_IDX;
			default: c = 4'h0;
		endcase
		if (d.kind == K_ABX) begin
			c = CYC_ABX;
		end else if (d.kind == K_ABY) begin
			c = CYC_ABY;
		end else if (d.wide) begin
			c = c + CYC_WIDE;
		end
		return c;
	endfunction

	// Byte stacked at each step, return address low byte first.
	function automatic logic [7:0] push_byte(input logic [3:0] k, input logic [15:0] pc, input logic [15:0] x,
		input logic [15:0] y, input logic [15:0] d, input logic [7:0] cc);
		case (k)
			4'h0: return pc[7:0];
			4'h1: return pc[15:8];
			4'h2: return y[7:0];
			4'h3: return y[15:8];
			4'h4: return x[7:0];
			4'h5: return x[15:8];
			4'h6: return d[15:8];
			4'h7: return d[7:0];
			default: return cc;
		endcase
	endfunction

	// ==========================================================
	// Effective address, branch condition and operand selection.
	wire [15:0] off8 = {8'h00, opnd_reg[7:0]};
	wire [15:0] rel8 = {{8{opnd_reg[7]}}, opnd_reg[7:0]};
	wire [15:0] idx_base = dec_reg.use_y ? y_reg : x_reg;
	wire [15:0] ea_w = (dec_reg.mode == M_IMM) ? ea_reg :
		(dec_reg.mode == M_DIR) ? off8 :
		(dec_reg.mode == M_EXT) ? opnd_reg :
		(dec_reg.mode == M_IDX) ? idx_base + off8 :
		(dec_reg.mode == M_REL) ? pc_reg + rel8 : 16'h0000;
	// The branch condition sits in the low nibble of the opcode byte, kept above the offset.
	wire [3:0] br_sel = opnd_reg[11:8];
	wire br_take = (br_sel == 4'h0) || (br_sel == 4'h4 && !ccr_reg[CC_C]) || (br_sel == 4'h5 && ccr_reg[CC_C])
		|| (br_sel == 4'h6 && !ccr_reg[CC_Z]) || (br_sel == 4'h7 && ccr_reg[CC_Z]);
	wire [15:0] src_w = (dec_reg.mode == M_IMM) ? opnd_reg : data_reg;
	// Second byte of a word sits one address above the first.
	wire [15:0] data_addr = ea_w + {15'h0000, dec_reg.wide && cnt_reg == 4'h1};
	wire pin_req = !nonmaskable_pin_request_n && !ccr_reg[CC_X];
	wire at_boundary = state_reg == ST_FETCH && ph_reg == 2'd0 && !pre_reg;
	wire rd_done = ph_reg == 2'd2;
	wire cpu_idle = state_reg == ST_IDLE;
	wire [7:0] pulled_ccr = {mem_rdata[7], mem_rdata[6] & ccr_reg[CC_X], mem_rdata[5:0]};
	wire x_clr_ok = (state_reg == ST_EXEC && dec_reg.kind == K_TAP) || (state_reg == ST_PULL && cnt_reg == 4'h0);

	ccad_alu u_alu (
		.kind(dec_reg.kind),
		.acc_d(acc_reg),
		.idx_x(x_reg),
		.idx_y(y_reg),
		.src(src_w),
		.ccr_in(ccr_reg),
		.res(alu_res),
		.ccr_out(alu_ccr)
	);

	// ==========================================================
	// Sequencer. Each memory read takes three phases: issue, wait, consume.
	always_ff @(posedge ref_clk) begin
		if (!resetn) begin
			state_reg <= ST_IDLE;
			dec_reg <= '{K_NOP, M_INH, 1'b0, 1'b0, 2'd0};
			{acc_reg, x_reg, y_reg, sp_reg, pc_reg} <= '0;
			{ea_reg, opnd_reg, data_reg} <= '0;
			ccr_reg <= CCR_RESET;
			{cnt_reg, cyc_reg, ph_reg, pre_reg, run_reg, stopped} <= '0;
			mem_req <= '0;
			reg_rdata <= 16'h0000;
		end else if (ce) begin
			mem_req.rd <= 1'b0;
			mem_req.wr <= 1'b0;
			ph_reg <= (ph_reg == 2'd0) ? 2'd0 : ph_reg + 2'd1;
			if (rd_done) begin
				ph_reg <= 2'd0;
			end
			case (state_reg)
				ST_IDLE: if (run_reg) begin
					state_reg <= ST_FETCH;
				end
				ST_FETCH: begin
					if (at_boundary && !run_reg) begin
						state_reg <= ST_IDLE;
					end else if (at_boundary && pin_req) begin
						state_reg <= ST_PUSH;
						cnt_reg <= 4'h0;
					end else if (ph_reg == 2'd0) begin
						mem_req <= '{pc_reg, 1'b1, 1'b0, 8'h00};
						pc_reg <= pc_reg + 16'h0001;
						ph_reg <= 2'd1;
					end else if (rd_done && mem_rdata == PRE_Y && !pre_reg) begin
						pre_reg <= 1'b1;
					end else if (rd_done) begin
						dec_reg <= decode(pre_reg, mem_rdata);
						ea_reg <= pc_reg;
						opnd_reg <= {mem_rdata, 8'h00};
						cnt_reg <= {2'b00, decode(pre_reg, mem_rdata).nopnd};
						state_reg <= (decode(pre_reg, mem_rdata).nopnd == 2'd0) ? ST_EXEC : ST_OPND;
					end
				end
				ST_OPND: begin
					if (ph_reg == 2'd0) begin
						mem_req <= '{pc_reg, 1'b1, 1'b0, 8'h00};
						pc_reg <= pc_reg + 16'h0001;
						ph_reg <= 2'd1;
					end else if (rd_done) begin
						// Bytes shift in high first; a branch keeps its opcode above the offset.
						opnd_reg <= (dec_reg.mode == M_REL) ? {opnd_reg[15:8], mem_rdata}
							: {opnd_reg[7:0], mem_rdata};
						cnt_reg <= cnt_reg - 4'h1;
						if (cnt_reg == 4'h1) begin
							state_reg <= (dec_reg.mode == M_IMM || dec_reg.mode == M_REL) ? ST_EXEC : ST_DATA;
							cnt_reg <= dec_reg.wide ? 4'h2 : 4'h1;
						end
					end
				end
				ST_DATA: begin
					if (ph_reg == 2'd0) begin
						mem_req <= '{data_addr, 1'b1, 1'b0, 8'h00};
						ph_reg <= 2'd1;
					end else if (rd_done) begin
						data_reg <= {data_reg[7:0], mem_rdata};
						cnt_reg <= cnt_reg - 4'h1;
						if (cnt_reg == 4'h1) begin
							state_reg <= ST_EXEC;
						end
					end
				end
				ST_EXEC: begin
					state_reg <= ST_FETCH;
					pre_reg <= 1'b0;
					ea_reg <= ea_w;
					cyc_reg <= doc_cycles(dec_reg);
					ccr_reg <= alu_ccr;
					case (dec_reg.kind)
						K_ADC, K_AND, K_ADD_WIDE_TO_DOUBLE_ACC: acc_reg <= alu_res;
						K_ABX: x_reg <= alu_res;
						K_ABY: y_reg <= alu_res;
						K_BR: if (br_take) begin
							pc_reg <= ea_w;
						end
						K_RTI: begin
							state_reg <= ST_PULL;
							cnt_reg <= 4'h0;
						end
						K_STOP: if (!ccr_reg[CC_S]) begin
							state_reg <= ST_STOP;
							stopped <= 1'b1;
						end
						default: ;
					endcase
				end
				// Only the pin request wakes the core from the stop condition.
				ST_STOP: if (!nonmaskable_pin_request_n) begin
					stopped <= 1'b0;
					state_reg <= ST_FETCH;
				end
				ST_PUSH: begin
					mem_req <= '{sp_reg, 1'b0, 1'b1, push_byte(cnt_reg, pc_reg, x_reg, y_reg, acc_reg, ccr_reg)};
					sp_reg <= sp_reg - 16'h0001;
					cnt_reg <= cnt_reg + 4'h1;
					if (cnt_reg == PUSH_LAST) begin
						ccr_reg[CC_X] <= 1'b1;
						ccr_reg[CC_I] <= 1'b1;
						state_reg <= ST_VEC;
						cnt_reg <= 4'h0;
					end
				end
				ST_VEC: begin
					if (ph_reg == 2'd0) begin
						mem_req <= '{VEC_PIN + {15'h0000, cnt_reg[0]}, 1'b1, 1'b0, 8'h00};
						ph_reg <= 2'd1;
					end else if (rd_done) begin
						pc_reg <= {pc_reg[7:0], mem_rdata};
						cnt_reg <= cnt_reg + 4'h1;
						if (cnt_reg == 4'h1) begin
							state_reg <= ST_FETCH;
						end
					end
				end
				ST_PULL: begin
					if (ph_reg == 2'd0) begin
						mem_req <= '{sp_reg + 16'h0001, 1'b1, 1'b0, 8'h00};
						sp_reg <= sp_reg + 16'h0001;
						ph_reg <= 2'd1;
					end else if (rd_done) begin
						cnt_reg <= cnt_reg + 4'h1;
						case (cnt_reg)
							4'h0: ccr_reg <= pulled_ccr;
							4'h1: acc_reg[7:0] <= mem_rdata;
							4'h2: acc_reg[15:8] <= mem_rdata;
							4'h3: x_reg[15:8] <= mem_rdata;
							4'h4: x_reg[7:0] <= mem_rdata;
							4'h5: y_reg[15:8] <= mem_rdata;
							4'h6: y_reg[7:0] <= mem_rdata;
							4'h7: pc_reg[15:8] <= mem_rdata;
							default: begin
								pc_reg[7:0] <= mem_rdata;
								state_reg <= ST_FETCH;
							end
						endcase
					end
				end
				default: state_reg <= ST_IDLE;
			endcase
			// Software may load core registers only while the core is idle.
			if (reg_wr && reg_addr == RA_CTRL) begin
				run_reg <= reg_wdata[0];
			end
			if (reg_wr && cpu_idle) begin
				case (reg_addr)
					RA_ACC: acc_reg <= reg_wdata;
					RA_X: x_reg <= reg_wdata;
					RA_Y: y_reg <= reg_wdata;
					RA_SP: sp_reg <= reg_wdata;
					RA_PC: pc_reg <= reg_wdata;
					// The pin mask can be set here but never cleared.
					RA_CCR: ccr_reg <= {reg_wdata[7], reg_wdata[6] | ccr_reg[CC_X], reg_wdata[5:0]};
					default: ;
				endcase
			end
			// Read data stand for exactly one cycle after the strobe.
			reg_rdata <= 16'h0000;
			if (reg_rd) begin
				case (reg_addr)
					RA_CTRL: reg_rdata <= {15'h0000, run_reg};
					RA_STATUS: reg_rdata <= {4'h0, cyc_reg, 2'b00, pre_reg, cpu_idle, state_reg[3:0]};
					RA_ACC: reg_rdata <= acc_reg;
					RA_X: reg_rdata <= x_reg;
					RA_Y: reg_rdata <= y_reg;
					RA_SP: reg_rdata <= sp_reg;
					RA_PC: reg_rdata <= pc_reg;
					default: reg_rdata <= {8'h00, ccr_reg};
				endcase
			end
		end
	end

	// ==========================================================
	// Checks on the masks, decode and flag behaviour.
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!resetn);

	a_reset_masks: assert property (@(posedge ref_clk) disable iff (1'b0) !resetn |=> ccr_reg[CC_X] && ccr_reg[CC_S])
		else $error("Masks not set after reset.");
	a_mask_before_vec: assert property (ce && state_reg == ST_PUSH && cnt_reg == PUSH_LAST
		|=> state_reg == ST_VEC && ccr_reg[CC_X] && ccr_reg[CC_I] && ph_reg == 2'd0)
		else $error("Masks not set between stacking and vector fetch.");
	a_x_no_hw_clear: assert property ($fell(ccr_reg[CC_X]) |-> $past(x_clr_ok))
		else $error("Pin mask cleared by hardware.");
	a_stop_as_nop: assert property (ce && state_reg == ST_EXEC && dec_reg.kind == K_STOP && ccr_reg[CC_S]
		|=> state_reg == ST_FETCH && !stopped)
		else $error("Halt entered while disabled.");
	a_direct_page: assert property (state_reg == ST_DATA && dec_reg.mode == M_DIR |-> ea_w[15:8] == 8'h00)
		else $error("Direct address high byte not zero.");
	a_abx_flags: assert property (ce && state_reg == ST_EXEC && dec_reg.kind == K_ABX
		|=> ccr_reg == $past(ccr_reg) && x_reg == $past(x_reg) + {8'h00, $past(acc_reg[7:0])})
		else $error("Index add wrong or flags changed.");
	a_and_flags: assert property (ce && state_reg == ST_EXEC && dec_reg.kind == K_AND
		|=> !ccr_reg[CC_V] && ccr_reg[CC_C] == $past(ccr_reg[CC_C]) && ccr_reg[CC_H] == $past(ccr_reg[CC_H]))
		else $error("AND flag update wrong.");
	a_wide_cycles: assert property (ce && state_reg == ST_EXEC && dec_reg.kind == K_ADD_WIDE_TO_DOUBLE_ACC && dec_reg.use_y
		|=> cyc_reg == 4'h7)
		else $error("Wide add cycle figure wrong.");
	a_wide_ext_cycles: assert property (ce && state_reg == ST_EXEC && dec_reg.kind == K_ADD_WIDE_TO_DOUBLE_ACC && dec_reg.mode == M_EXT
		|=> cyc_reg == 4'h6)
		else $error("Extended wide add cycle figure wrong.");
	a_branch_taken: assert property (ce && state_reg == ST_EXEC && dec_reg.kind == K_BR && br_take
		|=> pc_reg == $past(ea_w) ##1 (state_reg == ST_FETCH || state_reg == ST_IDLE || state_reg == ST_PUSH))
		else $error("Taken branch target wrong.");
endmodule
`default_nettype wire

// ==== tb/ccad_mem_model.sv ====
// Byte-wide memory model that answers CPU bus reads one cycle after the request.
`timescale 1ns/1ns
`default_nettype none
module ccad_mem_model
	import ccad_pkg::*;
(
	input wire logic ref_clk,
	input wire ccad_pkg::ccad_mem_req_t mem_req,
	output logic [7:0] mem_rdata
);
	logic [7:0] mem [0:65535];

	// ==========================================================
	// Contents start cleared so a stray fetch decodes as a known byte.
	initial begin
		mem_rdata = 8'h00;
		for (int i = 0; i < 65536; i++) begin
			mem[i] = 8'h00;
		end
	end

	// ==========================================================
	// Outside the answer cycle the data lines toggle, so a late sample reads garbage.
	always @(posedge ref_clk) begin
		if (mem_req.wr) begin
			mem[mem_req.addr] <= mem_req.wdata;
		end
		mem_rdata <= mem_req.rd ? mem[mem_req.addr] : ~mem_rdata;
	end
endmodule
`default_nettype wire

// ==== tb/testbench.sv ====
// Self-checking bench for the CPU front end with a memory model on its bus.
`timescale 1ns/1ns
`default_nettype none
`define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin fails++; $display("CHECK FAILED %s expected %h seen %h", n, e, g); end end
module testbench;
	import ccad_pkg::*;
	logic ref_clk, resetn, ce, reg_wr, reg_rd, pin_n, stopped;
	logic [2:0] reg_addr;
	logic [15:0] reg_wdata, reg_rdata;
	logic [7:0] mem_rdata;
	ccad_mem_req_t mem_req;
	int fails = 0;
	int checks = 0;
	int cyc = 0;

	ccad_core DUT (.ref_clk(ref_clk), .resetn(resetn), .ce(ce), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.mem_req(mem_req), .mem_rdata(mem_rdata), .nonmaskable_pin_request_n(pin_n),
		.stopped(stopped));
	ccad_mem_model MEM (.ref_clk(ref_clk), .mem_req(mem_req), .mem_rdata(mem_rdata));

	// ==========================================================
	// Clock and a cycle ceiling well above the thousand or so cycles the tests need.
	initial begin
		ref_clk = 1'b0;
		forever #5 ref_clk = ~ref_clk;
	end
	always @(posedge ref_clk) begin
		cyc++;
		if (cyc == 20000) begin
			fails++;
			report_and_stop();
		end
	end

	task automatic report_and_stop();
		$display("checks %0d fails %0d", checks, fails);
		if (fails == 0 && checks > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask

	// ==========================================================
	// Register port: one-cycle strobes, read data taken the cycle after.
	task automatic wr(input logic [2:0] a, input logic [15:0] d);
		@(posedge ref_clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge ref_clk);
		reg_wr <= 1'b0;
	endtask
	task automatic rd(input logic [2:0] a, output logic [15:0] d);
		@(posedge ref_clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge ref_clk);
		reg_rd <= 1'b0;
		#1;
		d = reg_rdata;
	endtask
	task automatic expect_reg(input string n, input logic [2:0] a, input logic [15:0] e);
		logic [15:0] v;
		rd(a, v);
		`CHK(n, e, v)
	endtask

	// ==========================================================
	// Program helpers: n bytes from the top of b, then a branch to itself.
	task automatic code(input logic [15:0] a, input logic [31:0] b, input int n);
		for (int i = 0; i < n; i++) begin
			MEM.mem[a + i] = b[31 - 8 * i -: 8];
		end
		MEM.mem[a + n] = 8'h20;
		MEM.mem[a + n + 1] = 8'hfe;
	endtask
	task automatic setup(input logic [15:0] d, x, y, input logic [7:0] cc);
		wr(RA_ACC, d);
		wr(RA_X, x);
		wr(RA_Y, y);
		wr(RA_CCR, {8'h00, cc});
	endtask
	// Stopping the run is only safe at a boundary, so idle is polled under a bound.
	task automatic run_at(input logic [15:0] pc);
		logic [15:0] s;
		wr(RA_PC, pc);
		wr(RA_CTRL, 16'h0001);
		repeat (80) @(posedge ref_clk);
		wr(RA_CTRL, 16'h0000);
		s = 16'h0000;
		for (int i = 0; i < 40 && s[4] !== 1'b1; i++) begin
			rd(RA_STATUS, s);
		end
		`CHK("idle", 1'b1, s[4])
	endtask

	// ==========================================================
	// Scenarios.
	task automatic t_reset();
		expect_reg("ccr", RA_CCR, 16'h00d0);
		$display("test reset done");
	endtask
	task automatic t_abx();
		setup(16'h00ff, 16'h10f0, 16'h0000, 8'hd0);
		code(16'h0100, 32'h3a000000, 1);
		run_at(16'h0100);
		expect_reg("x", RA_X, 16'h11ef);
		expect_reg("ccr", RA_CCR, 16'h00d0);
		expect_reg("pc", RA_PC, 16'h0101);
		$display("test abx done");
	endtask
	task automatic t_aby();
		setup(16'h00ff, 16'h0000, 16'h0001, 8'hd0);
		code(16'h0110, 32'h183a0000, 2);
		run_at(16'h0110);
		expect_reg("y", RA_Y, 16'h0100);
		expect_reg("x", RA_X, 16'h0000);
		expect_reg("pc", RA_PC, 16'h0112);
		$display("test aby done");
	endtask
	task automatic t_adc();
		setup(16'h7f00, 16'h0000, 16'h0000, 8'hd0);
		code(16'h0120, 32'h89010000, 2);
		run_at(16'h0120);
		expect_reg("d", RA_ACC, 16'h8000);
		expect_reg("ccr", RA_CCR, 16'h00fa);
		$display("test adc done");
	endtask
	task automatic t_and_dir();
		setup(16'hf000, 16'h0000, 16'h0000, 8'hd3);
		MEM.mem[16'h0040] = 8'h0f;
		MEM.mem[16'h0140] = 8'hff;
		code(16'h0130, 32'h94400000, 2);
		run_at(16'h0130);
		expect_reg("d", RA_ACC, 16'h0000);
		expect_reg("ccr", RA_CCR, 16'h00d5);
		$display("test and direct done");
	endtask
	task automatic t_add_wide_to_double_acc();
		setup(16'h1234, 16'h0000, 16'h0000, 8'hf0);
		MEM.mem[16'h0201] = 8'h80;
		MEM.mem[16'h0202] = 8'h00;
		code(16'h0141, 32'hf3020100, 3);
		run_at(16'h0141);
		expect_reg("d", RA_ACC, 16'h9234);
		expect_reg("ccr", RA_CCR, 16'h00f8);
		expect_reg("pc", RA_PC, 16'h0144);
		$display("test add_wide_to_double_acc done");
	endtask
	task automatic t_and_idx();
		setup(16'hff00, 16'h0300, 16'h0000, 8'hd2);
		MEM.mem[16'h0310] = 8'h3c;
		code(16'h0150, 32'ha4100000, 2);
		run_at(16'h0150);
		expect_reg("d", RA_ACC, 16'h3c00);
		expect_reg("ccr", RA_CCR, 16'h00d0);
		$display("test and indexed done");
	endtask
	task automatic t_stop();
		setup(16'h0000, 16'h0000, 16'h0000, 8'hd0);
		code(16'h0160, 32'hcf000000, 1);
		run_at(16'h0160);
		`CHK("stopped", 1'b0, stopped)
		expect_reg("pc", RA_PC, 16'h0161);
		$display("test stop done");
	endtask
	// The pin is held low while masked; clearing the mask must let it in once.
	task automatic t_irq();
		setup(16'h0000, 16'h0000, 16'h0000, 8'hd0);
		wr(RA_SP, 16'h01ff);
		MEM.mem[16'hfff4] = 8'h04;
		MEM.mem[16'hfff5] = 8'h00;
		code(16'h0400, 32'h00000000, 0);
		code(16'h0170, 32'h06000000, 1);
		pin_n <= 1'b0;
		run_at(16'h0170);
		pin_n <= 1'b1;
		expect_reg("pc", RA_PC, 16'h0400);
		expect_reg("ccr", RA_CCR, 16'h0050);
		`CHK("stacked ccr", 8'h00, MEM.mem[16'h01f7])
		`CHK("stacked pcl", 8'h71, MEM.mem[16'h01ff])
		`CHK("stacked pch", 8'h01, MEM.mem[16'h01fe])
		wr(RA_CCR, 16'h0000);
		expect_reg("ccr", RA_CCR, 16'h0040);
		$display("test interrupt done");
	endtask

	// ==========================================================
	// Main sequence.
	initial begin
		ce = 1'b1;
		resetn = 1'b0;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		reg_addr = 3'h0;
		reg_wdata = 16'h0000;
		pin_n = 1'b1;
		repeat (3) @(posedge ref_clk);
		resetn <= 1'b1;
		t_reset();
		t_abx();
		t_aby();
		t_adc();
		t_and_dir();
		t_add_wide_to_double_acc();
		t_and_idx();
		t_stop();
		t_irq();
		report_and_stop();
	end
endmodule
`default_nettype wire
